/* src/ccm_ctrl.sv */
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ccm_ctrl #(
    parameter int FLUSH_LIMIT = ccm_pkg::FLUSH_LIMIT_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [8:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic HOST_WR_VALID,
    output logic HOST_WR_CACHED,
    output logic MAINT_ACTIVE,
    output logic FLUSH_DONE,
    output logic [7:0] PERF_FEATURE_STATUS_FIELD,
    input wire logic LINK_CLK,
    input wire logic LINK_XFER,
    output logic DAT0_OUT,
    output logic DAT0_OE_N
);
    typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_MAINT} ccm_state_t;

    // capacity cap keeps one full flush inside the one-second limit
    localparam int FIT_LINES = FLUSH_LIMIT / ccm_pkg::NV_LINE_CYCLES - 1;
    localparam int CAP_LINES = (ccm_pkg::CACHE_LINES < FIT_LINES) ?
        ccm_pkg::CACHE_LINES : FIT_LINES;
    localparam logic [15:0] CAP = 16'(CAP_LINES);
    localparam logic [15:0] LINE_CYC = 16'(ccm_pkg::NV_LINE_CYCLES);
    localparam logic [31:0] LIMIT = 32'(FLUSH_LIMIT);

    function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
        hit = (a == o);
    endfunction : hit

    // places a one-bit flag at its position within a register byte
    function automatic logic [7:0] fld(input logic v, input int pos);
        fld = 8'(v) << pos;
    endfunction : fld

    ccm_pkg::ccm_ctl_t ctl;
    ccm_pkg::ccm_stat_t stat;
    ccm_state_t state;
    ccm_state_t next_state;
    logic [15:0] dirty;
    logic [15:0] line_cyc;
    logic [31:0] elapsed;
    logic off_req;
    logic flush_req;
    logic bus_busy;
    logic busy_link;
    logic off_seen;

    // register decode
    wire wr_maint = WR && hit(ADDR, ccm_pkg::OFS_MAINT_CTL);
    wire wr_cache = WR && hit(ADDR, ccm_pkg::OFS_CACHE_CTL);
    wire wr_cq = WR && hit(ADDR, ccm_pkg::OFS_CQ_CTL);
    wire wr_flush = WR && hit(ADDR, ccm_pkg::OFS_FLUSH)
        && WDATA[ccm_pkg::BIT_FLUSH];
    wire wr_off = WR && hit(ADDR, ccm_pkg::OFS_POWER_OFF)
        && WDATA[ccm_pkg::BIT_POWER_OFF];

    wire [7:0] rd_maint_sup = fld(1'b1, ccm_pkg::BIT_SUPPORT);
    wire [7:0] rd_cache_sup = fld(1'b1, ccm_pkg::BIT_SUPPORT);
    wire [7:0] rd_qdepth = {3'h0, ccm_pkg::QUEUE_DEPTH};
    wire [7:0] rd_maint_ctl = fld(ctl.maint_en, ccm_pkg::BIT_MAINT_EN)
        | fld(ctl.sustain_en, ccm_pkg::BIT_SUSTAIN_EN);
    wire [7:0] rd_cache_ctl = fld(ctl.cache_en, ccm_pkg::BIT_CACHE_EN);
    wire [7:0] rd_flush = fld(stat.flushing, ccm_pkg::BIT_FLUSH);
    wire [7:0] rd_cq = fld(ctl.cq_en, ccm_pkg::BIT_CQ_EN)
        | fld(ctl.cq_mode, ccm_pkg::BIT_CQ_MODE);
    wire [7:0] rd_status = fld(stat.flushing, ccm_pkg::BIT_ST_FLUSHING)
        | fld(stat.maint, ccm_pkg::BIT_ST_MAINT)
        | fld(stat.off_ready, ccm_pkg::BIT_ST_OFF_READY)
        | fld(stat.overrun, ccm_pkg::BIT_ST_OVERRUN)
        | fld(ctl.cq_mode, ccm_pkg::BIT_ST_CQ_SEQ);

    // cache contents have no read path at all
    wire [7:0] rd_mux =
        hit(ADDR, ccm_pkg::OFS_MAINT_SUP) ? rd_maint_sup :
        hit(ADDR, ccm_pkg::OFS_CACHE_SUP) ? rd_cache_sup :
        hit(ADDR, ccm_pkg::OFS_QDEPTH) ? rd_qdepth :
        hit(ADDR, ccm_pkg::OFS_MAINT_CTL) ? rd_maint_ctl :
        hit(ADDR, ccm_pkg::OFS_CACHE_CTL) ? rd_cache_ctl :
        hit(ADDR, ccm_pkg::OFS_FLUSH) ? rd_flush :
        hit(ADDR, ccm_pkg::OFS_CQ_CTL) ? rd_cq :
        hit(ADDR, ccm_pkg::OFS_STATUS) ? rd_status : 8'h00;

    wire [7:0] perf_field =
        (8'(1'b1) << ccm_pkg::SB_MAINT)
        | (8'(1'b1) << ccm_pkg::SB_CACHE)
        | (8'(ccm_pkg::QUEUE_DEPTH) << ccm_pkg::SB_QDEPTH_LSB);

    // maintenance needs both enables and a quiet bus
    wire maint_ok = ctl.maint_en && ctl.sustain_en && !bus_busy
        && !off_req && !stat.off_ready;

    // cache admission is decided here only, never by the host
    // once power-off is announced nothing new may be cached
    wire admit = HOST_WR_VALID && ctl.cache_en && (state != ST_FLUSH)
        && !off_req && !off_seen && (dirty < CAP);
    wire line_done = (state == ST_FLUSH) && (line_cyc == LINE_CYC - 16'h0001);
    wire flush_empty = (dirty == 16'h0000);
    wire flush_finish = (state == ST_FLUSH) && flush_empty;
    wire flush_late = (state == ST_FLUSH) && (elapsed == LIMIT);
    // clears apply on entry only; a request made during a pass re-arms
    wire flush_start = (state != ST_FLUSH) && (next_state == ST_FLUSH);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (flush_req || off_req)
                    next_state = ST_FLUSH;
                else if (maint_ok)
                    next_state = ST_MAINT;
            end
            ST_MAINT:
            begin
                // leaves at once so commands see no extra delay
                if (flush_req || off_req)
                    next_state = ST_FLUSH;
                else if (!maint_ok)
                    next_state = ST_IDLE;
            end
            ST_FLUSH:
            begin
                if (flush_empty)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctl <= '0;
        end
        else
        begin
            if (wr_maint)
            begin
                ctl.maint_en <= WDATA[ccm_pkg::BIT_MAINT_EN];
                ctl.sustain_en <= WDATA[ccm_pkg::BIT_SUSTAIN_EN];
            end
            if (wr_cache)
                ctl.cache_en <= WDATA[ccm_pkg::BIT_CACHE_EN];
            if (wr_cq)
            begin
                ctl.cq_en <= WDATA[ccm_pkg::BIT_CQ_EN];
                ctl.cq_mode <= WDATA[ccm_pkg::BIT_CQ_MODE];
            end
        end
    end

    // request latches: a new write wins over the clear on flush entry
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            flush_req <= 1'b0;
            off_req <= 1'b0;
        end
        else
        begin
            if (wr_flush)
                flush_req <= 1'b1;
            else if (flush_start)
                flush_req <= 1'b0;
            if (wr_off)
                off_req <= 1'b1;
            else if (flush_start)
                off_req <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state <= ST_IDLE;
            dirty <= 16'h0000;
            line_cyc <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            if (admit)
                dirty <= dirty + 16'h0001;
            else if (line_done && !flush_empty)
                dirty <= dirty - 16'h0001;
            if (line_done || state != ST_FLUSH || flush_empty)
                line_cyc <= 16'h0000;
            else
                line_cyc <= line_cyc + 16'h0001;
        end
    end

    // elapsed flush time, saturating at the limit
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            elapsed <= 32'h00000000;
        end
        else
        begin
            if (state != ST_FLUSH)
                elapsed <= 32'h00000000;
            else if (elapsed != LIMIT)
                elapsed <= elapsed + 32'h00000001;
        end
    end

    // overrun is sticky until the next flush starts
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            stat <= '0;
        end
        else
        begin
            if (flush_late)
                stat.overrun <= 1'b1;
            else if (flush_start)
                stat.overrun <= 1'b0;
            stat.flushing <= (next_state == ST_FLUSH);
            stat.maint <= (next_state == ST_MAINT);
            if (flush_finish && off_seen)
                stat.off_ready <= 1'b1;
        end
    end

    // remembers, until reset, that a power-off notification has been received
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            off_seen <= 1'b0;
        else if (off_req)
            off_seen <= 1'b1;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            RDATA <= 8'h00;
            HOST_WR_CACHED <= 1'b0;
            MAINT_ACTIVE <= 1'b0;
            FLUSH_DONE <= 1'b0;
            PERF_FEATURE_STATUS_FIELD <= 8'h00;
        end
        else
        begin
            RDATA <= RD ? rd_mux : 8'h00;
            HOST_WR_CACHED <= admit;
            MAINT_ACTIVE <= (next_state == ST_MAINT);
            FLUSH_DONE <= flush_finish;
            PERF_FEATURE_STATUS_FIELD <= perf_field;
        end
    end

    // link transaction level into the core clock
    ccm_sync3 u_xfer_sync (
        .clk(MCLK),
        .rst(RST),
        .d(LINK_XFER),
        .q(bus_busy)
    );

    // flushing level into the link clock; busy drops only after the
    // core has left the flush with nothing dirty left
    ccm_sync3 u_busy_sync (
        .clk(LINK_CLK),
        .rst(RST),
        .d(stat.flushing),
        .q(busy_link)
    );

    always_ff @(posedge LINK_CLK or posedge RST)
    begin
        if (RST)
        begin
            DAT0_OUT <= 1'b1;
            DAT0_OE_N <= 1'b1;
        end
        else
        begin
            // only ever pulled low; released, it rests on the host pull-up
            DAT0_OUT <= 1'b0;
            DAT0_OE_N <= !busy_link;
        end
    end
endmodule : ccm_ctrl
`default_nettype wire

/* src/ccm_pkg.sv */
package ccm_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    // register byte numbers
    localparam logic [8:0] OFS_MAINT_SUP = 9'h002;
    localparam logic [8:0] OFS_CACHE_SUP = 9'h004;
    localparam logic [8:0] OFS_QDEPTH = 9'h006;
    localparam logic [8:0] OFS_MAINT_CTL = 9'h103;
    localparam logic [8:0] OFS_CACHE_CTL = 9'h104;
    localparam logic [8:0] OFS_FLUSH = 9'h105;
    localparam logic [8:0] OFS_CQ_CTL = 9'h106;
    localparam logic [8:0] OFS_POWER_OFF = 9'h107;
    localparam logic [8:0] OFS_STATUS = 9'h108;
    // field positions
    localparam int BIT_SUPPORT = 0;
    localparam int BIT_MAINT_EN = 0;
    localparam int BIT_SUSTAIN_EN = 1;
    localparam int BIT_CACHE_EN = 0;
    localparam int BIT_FLUSH = 0;
    localparam int BIT_CQ_EN = 0;
    localparam int BIT_CQ_MODE = 1;
    localparam int BIT_POWER_OFF = 0;
    localparam int BIT_ST_FLUSHING = 0;
    localparam int BIT_ST_MAINT = 1;
    localparam int BIT_ST_OFF_READY = 2;
    localparam int BIT_ST_OVERRUN = 3;
    localparam int BIT_ST_CQ_SEQ = 4;
    // status block bits 328..335 as a byte, bit 0 is 328
    localparam int SB_MAINT = 0;
    localparam int SB_CACHE = 2;
    localparam int SB_QDEPTH_LSB = 3;
    // reset values
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [4:0] QUEUE_DEPTH = 5'h1F;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int FLUSH_LIMIT_S = 1;
    localparam int FLUSH_LIMIT_CYCLES = FLUSH_LIMIT_S * CLK_MHZ * 1000000;
    localparam int NV_LINE_NS = 2000;
    localparam int NV_LINE_CYCLES = (NV_LINE_NS * CLK_MHZ + 999) / 1000;
    localparam int CACHE_LINES = 1024;
    localparam int LINE_W = 16;

    typedef struct packed {
        logic sustain_en;
        logic maint_en;
        logic cache_en;
        logic cq_en;
        logic cq_mode;
    } ccm_ctl_t;

    typedef struct packed {
        logic overrun;
        logic off_ready;
        logic maint;
        logic flushing;
    } ccm_stat_t;
endpackage : ccm_pkg

/* src/ccm_sync3.sv */
`timescale 1ns/1ns
`default_nettype none
// three stages; the output moves only when stages two and three agree
module ccm_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                q <= s3;
            end
        end
    end
endmodule : ccm_sync3
`default_nettype wire

/* verif/ccm_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module ccm_properties #(
    parameter int FLUSH_LIMIT = 1000
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [8:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic HOST_WR_VALID,
    input wire logic HOST_WR_CACHED,
    input wire logic MAINT_ACTIVE,
    input wire logic FLUSH_DONE,
    input wire logic [7:0] PERF_FEATURE_STATUS_FIELD,
    input wire logic LINK_XFER,
    input wire logic DAT0_OUT,
    input wire logic DAT0_OE_N
);
    logic cen, off, fl;
    logic [1:0] men;
    logic [6:0] cnt;
    wire wra = WR && WDATA[0];
    wire fls = wra && (ADDR == 9'h105 || ADDR == 9'h107);

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cen <= 1'b0;
            off <= 1'b0;
            fl <= 1'b0;
            men <= 2'b00;
            cnt <= 7'h00;
        end
        else
        begin
            if (WR && ADDR == 9'h104)
                cen <= WDATA[0];
            if (WR && ADDR == 9'h103)
                men <= WDATA[1:0];
            if (wra && ADDR == 9'h107)
                off <= 1'b1;
            fl <= fls || (fl && !FLUSH_DONE);
            // saturates so a long flush keeps the busy check armed
            cnt <= fl ? cnt + {6'h00, cnt != 7'h7F} : 7'h00;
        end
    end

    AST_FIELD: assert property (
        !$past(RST) |-> PERF_FEATURE_STATUS_FIELD == 8'hFD)
        else $error("feature status field wrong");
    AST_CACHED: assert property (
        HOST_WR_CACHED |-> $past(HOST_WR_VALID) && $past(cen) && !$past(off))
        else $error("line cached without cause");
    AST_FLUSH: assert property (
        wra && ADDR == 9'h105 |-> ##[1:FLUSH_LIMIT] FLUSH_DONE)
        else $error("flush too slow");
    AST_OFF_FLUSH: assert property (
        wra && ADDR == 9'h107 && !off |-> ##[1:FLUSH_LIMIT] FLUSH_DONE)
        else $error("power-off flush too slow");
    AST_BUSY: assert property (
        cnt > 7'h63 |-> !DAT0_OE_N && !DAT0_OUT)
        else $error("dat0 not busy in flush");
    AST_RELEASE: assert property (
        $rose(DAT0_OE_N) |-> !fl)
        else $error("dat0 released before flush end");
    AST_MAINT_EN: assert property (
        (men != 2'b11) [*4] |-> !MAINT_ACTIVE)
        else $error("maintenance while disabled");
    AST_IDLE: assert property (
        LINK_XFER [*8] |-> !MAINT_ACTIVE)
        else $error("maintenance during transaction");
    AST_POWEROFF: assert property (
        off [*4] |-> !MAINT_ACTIVE)
        else $error("maintenance after power-off");
endmodule : ccm_properties

bind ccm_ctrl ccm_properties #(.FLUSH_LIMIT(FLUSH_LIMIT)) u_prop (
    .MCLK, .RST, .ADDR, .WDATA, .WR, .HOST_WR_VALID, .HOST_WR_CACHED,
    .MAINT_ACTIVE, .FLUSH_DONE, .PERF_FEATURE_STATUS_FIELD, .LINK_XFER,
    .DAT0_OUT, .DAT0_OE_N);
`default_nettype wire

/* verif/ccm_link_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ccm_link_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic want,
    input wire logic dat0_out,
    input wire logic dat0_oe_n,
    output logic xfer,
    output logic busy
);
    // dat0 has a pull-up, so a released line reads high
    wire dat0 = dat0_oe_n ? 1'b1 : dat0_out;
    assign busy = !dat0;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            xfer <= 1'b0;
        else
            xfer <= want && !busy;
    end
endmodule : ccm_link_host
`default_nettype wire

/* verif/tb_card_cache_maintenance_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_card_cache_maintenance_ctrl;
    logic MCLK = 1'b0;
    logic LINK_CLK = 1'b0;
    logic RST = 1'b1;
    logic [8:0] ADDR = 9'h000;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic HOST_WR_VALID = 1'b0;
    logic want = 1'b0;
    logic [7:0] lf = 8'h17;
    wire [7:0] RDATA, PERF_FEATURE_STATUS_FIELD;
    wire HOST_WR_CACHED, MAINT_ACTIVE, FLUSH_DONE, LINK_XFER;
    wire DAT0_OUT, DAT0_OE_N, busy;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    // cache cap is 1000/250-1 = 3 lines at this limit
    ccm_ctrl #(.FLUSH_LIMIT(1000)) DUT (
        .MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .HOST_WR_VALID,
        .HOST_WR_CACHED, .MAINT_ACTIVE, .FLUSH_DONE,
        .PERF_FEATURE_STATUS_FIELD, .LINK_CLK, .LINK_XFER, .DAT0_OUT,
        .DAT0_OE_N);
    ccm_link_host u_host (.clk(LINK_CLK), .rst(RST), .want(want),
        .dat0_out(DAT0_OUT), .dat0_oe_n(DAT0_OE_N), .xfer(LINK_XFER),
        .busy(busy));

    initial forever #4 MCLK = ~MCLK;
    initial
    begin
        #1;
        forever #40 LINK_CLK = ~LINK_CLK;
    end

    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt

    task automatic stop_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        chk(RDATA, e);
    endtask : rd

    task automatic put(input logic e);
        @(posedge MCLK);
        HOST_WR_VALID <= 1'b1;
        @(posedge MCLK);
        HOST_WR_VALID <= 1'b0;
        @(negedge MCLK);
        chk(8'(HOST_WR_CACHED), 8'(e));
    endtask : put

    task automatic wait_done(output int n, output logic b);
        n = 0;
        b = 1'b0;
        while (FLUSH_DONE !== 1'b1 && n < 2000)
        begin
            @(negedge MCLK);
            n++;
            b |= busy;
        end
    endtask : wait_done

    task automatic wait_maint(input logic v);
        int n;
        n = 0;
        while (MAINT_ACTIVE !== v && n < 200)
        begin
            @(negedge MCLK);
            n++;
        end
        chk(8'(MAINT_ACTIVE), 8'(v));
    endtask : wait_maint

    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    initial
    begin
        int n;
        logic b;
        // the first link edge at 41 ns falls inside this reset as well
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        repeat (2) @(negedge MCLK);
        chk(PERF_FEATURE_STATUS_FIELD, 8'hFD);
        rd(9'h002, 8'h01);
        rd(9'h004, 8'h01);
        rd(9'h006, 8'h1F);
        wr(9'h004, 8'h00);
        rd(9'h004, 8'h01);
        rd(9'h1FF, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            lf = nxt(lf);
            wr(9'h106, lf);
            rd(9'h106, lf & 8'h03);
            rd(9'h108, {3'h0, lf[1], 4'h0});
        end
        wr(9'h106, 8'h03);
        rd(9'h108, 8'h10);
        wr(9'h106, 8'h01);
        put(1'b0);
        wr(9'h104, 8'h01);
        rd(9'h104, 8'h01);
        for (int i = 0; i < 4; i++)
            put(i < 3);
        wr(9'h105, 8'h01);
        rd(9'h105, 8'h01);
        wait_done(n, b);
        chk(8'(n > 700 && n < 1000), 8'h01);
        chk(8'(b), 8'h01);
        repeat (10) @(posedge LINK_CLK);
        @(negedge MCLK);
        chk(8'(busy), 8'h00);
        rd(9'h105, 8'h00);
        put(1'b1);
        wr(9'h103, 8'h01);
        repeat (20) @(negedge MCLK);
        chk(8'(MAINT_ACTIVE), 8'h00);
        wr(9'h103, 8'h03);
        wait_maint(1'b1);
        rd(9'h108, 8'h02);
        @(posedge MCLK);
        want <= 1'b1;
        wait_maint(1'b0);
        put(1'b1);
        repeat (40) @(negedge MCLK);
        chk(8'(MAINT_ACTIVE), 8'h00);
        @(posedge MCLK);
        want <= 1'b0;
        wait_maint(1'b1);
        wr(9'h107, 8'h01);
        repeat (4) @(negedge MCLK);
        chk(8'(MAINT_ACTIVE), 8'h00);
        wait_done(n, b);
        chk(8'(n < 1000), 8'h01);
        rd(9'h108, 8'h04);
        put(1'b0);
        stop_test();
    end
endmodule : tb_card_cache_maintenance_ctrl
`default_nettype wire
